// ==== cra_defs.svh ====
// Constants of the count rate averager: offsets, reset values and timing counts.
// How it works
// - Normal mode shows mean of sixty one-second samples.
// - Normal display follows a step within one minute.
// - Two percent setting averages up to 1199 samples (9604 capped to twenty minutes).
// - Five percent setting averages up to 1199 samples (1537 capped to twenty minutes).
// - Ten percent setting averages up to 419 samples (384 rounded up to seven minutes).
// - Accuracy setting comes from static jumper pins.
// - Accuracy settings refresh display once per minute.
// - Two sigma change shows value, refreshes every second.
// - Below two sigma, refresh returns to once per minute.
// - Accuracy settings integrate at most twenty minutes.
// - Dead-time correction applied and recomputed every second.
// - Alarm uses background-subtracted, calibrated corrected rate.
`ifndef CRA_DEFS_SVH
`define CRA_DEFS_SVH

`define CRA_SAMPLE_W       24
`define CRA_FIFO_DEPTH     16
`define CRA_NORM_WIN       60
`define CRA_WIN_2PCT       9604
`define CRA_WIN_5PCT       1537
`define CRA_WIN_10PCT      384
`define CRA_MAX_MINUTES    20
`define CRA_SEC_PER_MIN    60
`define CRA_SIGMA_MULT     2
`define CRA_CLK_PERIOD_NS  10
`define CRA_TICK_PERIOD_MS 1000
`define CRA_TICK_CYCLES    ((`CRA_TICK_PERIOD_MS * 1000000) / `CRA_CLK_PERIOD_NS)

`define CRA_MIN_BASE       7'h40

`define CRA_REG_TAU        8'h00
`define CRA_REG_BKG        8'h04
`define CRA_REG_CALK       8'h08
`define CRA_REG_ALARM_SP   8'h0C
`define CRA_REG_DISPLAY    8'h10
`define CRA_REG_ALARM_VAL  8'h14
`define CRA_REG_STATUS     8'h18

`define CRA_TAU_RST        32'h00000000
`define CRA_BKG_RST        32'h00000000
`define CRA_CALK_RST       32'h00010000
`define CRA_ALARM_SP_RST   32'hFFFFFFFF

`endif

// ==== cra_pkg.sv ====
// Types shared by the count rate averager files.
package cra_pkg;
  typedef enum logic [1:0] {
    CRA_MODE_NORMAL = 2'b00,
    CRA_MODE_2PCT   = 2'b01,
    CRA_MODE_5PCT   = 2'b10,
    CRA_MODE_10PCT  = 2'b11
  } cra_mode_t;

  typedef enum logic [3:0] {
    CRA_S_IDLE = 4'b0000,
    CRA_S_RDS  = 4'b0001,
    CRA_S_UPS  = 4'b0010,
    CRA_S_RDM  = 4'b0011,
    CRA_S_WTM  = 4'b0100,
    CRA_S_UPM  = 4'b0101,
    CRA_S_MEAN = 4'b0110,
    CRA_S_DIV  = 4'b0111,
    CRA_S_DIVX = 4'b1000,
    CRA_S_EVAL = 4'b1001
  } cra_state_t;

  typedef struct packed {
    logic [31:0] tau;
    logic [31:0] bkg;
    logic [31:0] calk;
    logic [31:0] alarm_sp;
  } cra_cfg_t;

  typedef struct packed {
    logic [31:0] display;
    logic [31:0] alarm_value;
    logic        alarm;
    logic        fast;
  } cra_result_t;
endpackage

// ==== cra_fifo.sv ====
// Sample FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module cra_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;
  logic [AW:0]   next_count;

  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // Ready is a flop so the full flag never glitches back into the source.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count       <= next_count;
      in_ready_o  <= (next_count < (AW+1)'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end

  // Storage needs no reset; only the pointers qualify it.
  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end
endmodule

// ==== cra_ram.sv ====
// Single-port memory for the second and minute rings, registered read data.
`timescale 1ns/10ps
module cra_ram #(
  parameter int W  = 32,
  parameter int AW = 7
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [W-1:0]  wdata_i,
  output logic [W-1:0]       rdata_o
);
  logic [W-1:0] mem [2**AW];

  // Read before write; the caller never reads an address it writes at once.
  always_ff @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    rdata_o <= mem[addr_i];
  end
endmodule

// ==== cra_top.sv ====
// Count rate averager: per-second sampling, windowed mean, dead-time and alarm.
`timescale 1ns/10ps
`include "cra_defs.svh"
module cra_top
  import cra_pkg::*;
#(
  parameter int SAMPLE_W    = `CRA_SAMPLE_W,
  parameter int FIFO_DEPTH  = `CRA_FIFO_DEPTH,
  parameter int TICK_CYCLES = `CRA_TICK_CYCLES
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  input  wire logic                sample_valid_i,
  output logic                     sample_ready_o,
  input  wire logic                jmp_2pct_i,
  input  wire logic                jmp_5pct_i,
  input  wire logic                jmp_10pct_i,
  output logic [31:0]              display_o,
  output logic                     display_stb_o,
  output logic                     alarm_o
);

  // Jumper code to mode; several or no jumpers fall back to normal.
  function automatic cra_mode_t cra_decode(input logic [2:0] j);
    case (j)
      3'b001:  cra_decode = CRA_MODE_2PCT;
      3'b010:  cra_decode = CRA_MODE_5PCT;
      3'b100:  cra_decode = CRA_MODE_10PCT;
      default: cra_decode = CRA_MODE_NORMAL;
    endcase
  endfunction

  // Completed minutes kept beside the running minute, so the window stays within twenty.
  function automatic logic [4:0] cra_min_len(input cra_mode_t m);
    int w;
    int n;
    case (m)
      CRA_MODE_2PCT:  w = `CRA_WIN_2PCT;
      CRA_MODE_5PCT:  w = `CRA_WIN_5PCT;
      CRA_MODE_10PCT: w = `CRA_WIN_10PCT;
      default:        w = `CRA_NORM_WIN;
    endcase
    n = (w + `CRA_SEC_PER_MIN - 1) / `CRA_SEC_PER_MIN;
    if (n > `CRA_MAX_MINUTES) n = `CRA_MAX_MINUTES;
    cra_min_len = 5'(n - 1);
  endfunction

  // Clamp a wide unsigned value into 32 bits.
  function automatic logic [31:0] cra_sat32(input logic [63:0] v);
    cra_sat32 = (v[63:32] != 32'h0) ? 32'hFFFFFFFF : v[31:0];
  endfunction

  // Byte-lane merge for register writes.
  function automatic logic [31:0] cra_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    cra_merge = r;
  endfunction

  // Integer square root by bit trial.
  function automatic logic [19:0] cra_isqrt(input logic [39:0] v);
    logic [19:0] r;
    logic [19:0] c;
    r = 20'h0;
    for (int i = 19; i >= 0; i--) begin
      c = r | (20'h1 << i);
      if (({20'h0, c} * {20'h0, c}) <= v) r = c;
    end
    cra_isqrt = r;
  endfunction

  cra_cfg_t      cfg;
  cra_result_t   res;
  cra_state_t    state;
  cra_mode_t     cur_mode;
  cra_mode_t     jmp_mode;
  logic [2:0]    jmp_s1;
  logic [2:0]    jmp_s2;
  logic [2:0]    jmp_s3;
  logic [2:0]    jmp_q;
  logic [31:0]   tick_cnt;
  logic          tick;
  logic          pend;
  logic [SAMPLE_W-1:0] fifo_data;
  logic          fifo_valid;
  logic          fifo_pop;
  logic          mem_we;
  logic [6:0]    mem_addr;
  logic [31:0]   mem_wdata;
  logic [31:0]   mem_rdata;
  logic [SAMPLE_W-1:0] smp;
  logic [31:0]   sec_sum;
  logic [5:0]    sec_ptr;
  logic [5:0]    sec_fill;
  logic [31:0]   part_sum;
  logic [5:0]    part_cnt;
  logic [39:0]   min_total;
  logic [4:0]    min_ptr;
  logic [4:0]    min_fill;
  logic [4:0]    min_len;
  logic          minute_mark;
  logic          shown_valid;
  logic [39:0]   cur_sum;
  logic [15:0]   cur_den;
  logic [31:0]   mean;
  logic [31:0]   corr;
  logic [31:0]   shown_mean;
  logic [15:0]   shown_den;
  logic [20:0]   shown_thr;
  logic [63:0]   dv_num;
  logic [40:0]   dv_rem;
  logic [39:0]   dv_den;
  logic [63:0]   dv_q;
  logic [5:0]    dv_cnt;
  logic          dv_tau;
  logic          wb_req;
  logic [31:0]   next_rd_dat;
  logic [40:0]   next_rem_sh;
  logic          next_fit;
  logic [63:0]   next_tau_prod;
  logic [31:0]   next_sub;
  logic [63:0]   next_dval;
  logic [31:0]   next_diff;
  logic [47:0]   next_dev;
  logic          next_big;

  assign jmp_mode = cra_decode(jmp_q);
  assign min_len  = cra_min_len(cur_mode);
  assign fifo_pop = (state == CRA_S_IDLE) && pend && fifo_valid && (jmp_mode == cur_mode);
  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign display_o     = res.display;
  assign alarm_o       = res.alarm;

  cra_fifo #(
    .W     (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (sample_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  cra_ram #(
    .W  (32),
    .AW (7)
  ) u_ram (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // Jumper pins are static straps, but still cross in through three flops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jmp_s1 <= 3'h0;
      jmp_s2 <= 3'h0;
      jmp_s3 <= 3'h0;
      jmp_q  <= 3'h0;
    end else begin
      jmp_s1 <= {jmp_10pct_i, jmp_5pct_i, jmp_2pct_i};
      jmp_s2 <= jmp_s1;
      jmp_s3 <= jmp_s2;
      if (jmp_s2 == jmp_s3) jmp_q <= jmp_s3;
    end
  end

  // One-second sample tick; pend holds it until a sample is there to take.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
      pend     <= 1'b0;
    end else begin
      if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
        tick_cnt <= 32'h0;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
        tick     <= 1'b0;
      end
      if (tick) pend <= 1'b1;
      else if (fifo_pop) pend <= 1'b0;
    end
  end

  // Divider step, dead-time product and change test terms.
  always_comb begin
    next_rem_sh   = {dv_rem[39:0], dv_num[63]};
    next_fit      = (next_rem_sh >= {1'b0, dv_den});
    next_tau_prod = cra_sat32(dv_q) * cfg.tau;
    next_sub      = (corr > cfg.bkg) ? (corr - cfg.bkg) : 32'h0;
    next_dval     = next_sub * cfg.calk;
    next_diff     = (mean > shown_mean) ? (mean - shown_mean) : (shown_mean - mean);
    next_dev      = next_diff * shown_den;
    next_big      = (next_dev >= {27'h0, shown_thr});
  end

  // Averaging sequence, run once per accepted sample.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= CRA_S_IDLE;
      cur_mode    <= CRA_MODE_NORMAL;
      mem_we      <= 1'b0;
      mem_addr    <= 7'h0;
      mem_wdata   <= 32'h0;
      smp         <= '0;
      sec_sum     <= 32'h0;
      sec_ptr     <= 6'h0;
      sec_fill    <= 6'h0;
      part_sum    <= 32'h0;
      part_cnt    <= 6'h0;
      min_total   <= 40'h0;
      min_ptr     <= 5'h0;
      min_fill    <= 5'h0;
      minute_mark <= 1'b0;
      shown_valid <= 1'b0;
      cur_sum     <= 40'h0;
      cur_den     <= 16'h0;
      mean        <= 32'h0;
      corr        <= 32'h0;
      shown_mean  <= 32'h0;
      shown_den   <= 16'h0;
      shown_thr   <= 21'h0;
      dv_num      <= 64'h0;
      dv_rem      <= 41'h0;
      dv_den      <= 40'h0;
      dv_q        <= 64'h0;
      dv_cnt      <= 6'h0;
      dv_tau      <= 1'b0;
      res         <= '0;
      display_stb_o <= 1'b0;
    end else begin
      mem_we        <= 1'b0;
      display_stb_o <= 1'b0;
      case (state)
        CRA_S_IDLE: begin
          if (jmp_mode != cur_mode) begin
            // A new setting restarts integration from empty rings.
            cur_mode    <= jmp_mode;
            sec_sum     <= 32'h0;
            sec_ptr     <= 6'h0;
            sec_fill    <= 6'h0;
            part_sum    <= 32'h0;
            part_cnt    <= 6'h0;
            min_total   <= 40'h0;
            min_ptr     <= 5'h0;
            min_fill    <= 5'h0;
            shown_valid <= 1'b0;
            res.fast    <= 1'b0;
          end else if (fifo_pop) begin
            smp      <= fifo_data;
            mem_addr <= {1'b0, sec_ptr};
            state    <= CRA_S_RDS;
          end
        end
        CRA_S_RDS: state <= CRA_S_UPS;
        CRA_S_UPS: begin
          // Running sum of the sixty newest seconds; the oldest drops out.
          sec_sum   <= sec_sum + 32'(smp)
                       - ((sec_fill == 6'd`CRA_NORM_WIN) ? {8'h0, mem_rdata[23:0]} : 32'h0);
          mem_we    <= 1'b1;
          mem_wdata <= 32'(smp);
          sec_ptr   <= (sec_ptr == 6'd`CRA_NORM_WIN - 6'd1) ? 6'h0 : sec_ptr + 6'h1;
          if (sec_fill != 6'd`CRA_NORM_WIN) sec_fill <= sec_fill + 6'h1;
          part_sum  <= part_sum + 32'(smp);
          part_cnt  <= part_cnt + 6'h1;
          if ((cur_mode != CRA_MODE_NORMAL) && (part_cnt == 6'd`CRA_SEC_PER_MIN - 6'd1)) begin
            state <= CRA_S_RDM;
          end else begin
            state <= CRA_S_MEAN;
          end
        end
        CRA_S_RDM: begin
          mem_addr <= `CRA_MIN_BASE + {2'h0, min_ptr};
          state    <= CRA_S_WTM;
        end
        CRA_S_WTM: state <= CRA_S_UPM;
        CRA_S_UPM: begin
          // Close the minute into a ring that never spans more than twenty minutes.
          min_total <= min_total + {8'h0, part_sum}
                       - ((min_fill == min_len) ? {8'h0, mem_rdata} : 40'h0);
          mem_we    <= 1'b1;
          mem_wdata <= part_sum;
          min_ptr   <= (min_ptr >= min_len - 5'h1) ? 5'h0 : min_ptr + 5'h1;
          if (min_fill != min_len) min_fill <= min_fill + 5'h1;
          part_sum    <= 32'h0;
          part_cnt    <= 6'h0;
          minute_mark <= 1'b1;
          state       <= CRA_S_MEAN;
        end
        CRA_S_MEAN: begin
          if (cur_mode == CRA_MODE_NORMAL) begin
            cur_sum <= {8'h0, sec_sum};
            cur_den <= {10'h0, sec_fill};
            dv_num  <= {32'h0, sec_sum};
            dv_den  <= {34'h0, sec_fill};
          end else begin
            cur_sum <= min_total + {8'h0, part_sum};
            cur_den <= {10'h0, part_cnt} + 16'(min_fill) * 16'd`CRA_SEC_PER_MIN;
            dv_num  <= {24'h0, min_total + {8'h0, part_sum}};
            dv_den  <= {24'h0, 16'(part_cnt) + 16'(min_fill) * 16'd`CRA_SEC_PER_MIN};
          end
          dv_rem <= 41'h0;
          dv_q   <= 64'h0;
          dv_cnt <= 6'h0;
          dv_tau <= 1'b0;
          state  <= CRA_S_DIV;
        end
        CRA_S_DIV: begin
          // Restoring division, one quotient bit per clock.
          dv_rem <= next_fit ? (next_rem_sh - {1'b0, dv_den}) : next_rem_sh;
          dv_num <= {dv_num[62:0], 1'b0};
          dv_q   <= {dv_q[62:0], next_fit};
          dv_cnt <= dv_cnt + 6'h1;
          if (dv_cnt == 6'h3F) state <= CRA_S_DIVX;
        end
        CRA_S_DIVX: begin
          if (!dv_tau) begin
            // Dead-time: rate / (1 - rate * tau), tau scaled by 2^-40 s per count.
            mean   <= cra_sat32(dv_q);
            dv_num <= {cra_sat32(dv_q), 32'h0};
            dv_den <= {7'h0, 33'h100000000 - {1'b0, next_tau_prod[39:8]}};
            dv_rem <= 41'h0;
            dv_q   <= 64'h0;
            dv_cnt <= 6'h0;
            dv_tau <= 1'b1;
            if (next_tau_prod[63:40] != 24'h0) begin
              corr  <= 32'hFFFFFFFF;   // Paralysed detector: rate pinned at full scale.
              state <= CRA_S_EVAL;
            end else begin
              state <= CRA_S_DIV;
            end
          end else begin
            corr  <= cra_sat32(dv_q);
            state <= CRA_S_EVAL;
          end
        end
        CRA_S_EVAL: begin
          minute_mark <= 1'b0;
          if ((cur_mode == CRA_MODE_NORMAL) || !shown_valid || next_big || minute_mark) begin
            // Normal mode refreshes every second; accuracy modes on a minute or a jump.
            res.display     <= corr;
            res.alarm_value <= cra_sat32({16'h0, next_dval[63:16]});
            res.alarm       <= (cra_sat32({16'h0, next_dval[63:16]}) >= cfg.alarm_sp);
            display_stb_o   <= 1'b1;
            shown_valid     <= 1'b1;
            shown_mean      <= mean;
            shown_den       <= cur_den;
            shown_thr       <= 21'(`CRA_SIGMA_MULT) * {1'b0, cra_isqrt(cur_sum)};
          end
          res.fast <= (cur_mode != CRA_MODE_NORMAL) && shown_valid && next_big;
          state    <= CRA_S_IDLE;
        end
        default: state <= CRA_S_IDLE;
      endcase
    end
  end

  // Register read mux.
  always_comb begin
    case ({wb_adr_i[7:2], 2'b00})
      `CRA_REG_TAU:       next_rd_dat = cfg.tau;
      `CRA_REG_BKG:       next_rd_dat = cfg.bkg;
      `CRA_REG_CALK:      next_rd_dat = cfg.calk;
      `CRA_REG_ALARM_SP:  next_rd_dat = cfg.alarm_sp;
      `CRA_REG_DISPLAY:   next_rd_dat = res.display;
      `CRA_REG_ALARM_VAL: next_rd_dat = res.alarm_value;
      `CRA_REG_STATUS:    next_rd_dat = {24'h0, 1'b0, jmp_q, res.alarm, res.fast, cur_mode};
      default:            next_rd_dat = 32'h0;
    endcase
  end

  // Wishbone slave: every access is acked one clock later, unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0;
      cfg.tau      <= `CRA_TAU_RST;
      cfg.bkg      <= `CRA_BKG_RST;
      cfg.calk     <= `CRA_CALK_RST;
      cfg.alarm_sp <= `CRA_ALARM_SP_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i) begin
        case ({wb_adr_i[7:2], 2'b00})
          `CRA_REG_TAU:      cfg.tau      <= cra_merge(cfg.tau, wb_dat_i, wb_sel_i);
          `CRA_REG_BKG:      cfg.bkg      <= cra_merge(cfg.bkg, wb_dat_i, wb_sel_i);
          `CRA_REG_CALK:     cfg.calk     <= cra_merge(cfg.calk, wb_dat_i, wb_sel_i);
          `CRA_REG_ALARM_SP: cfg.alarm_sp <= cra_merge(cfg.alarm_sp, wb_dat_i, wb_sel_i);
          default: ;
        endcase
      end
      if (wb_req && !wb_we_i) wb_dat_o <= next_rd_dat;
    end
  end
endmodule

// ==== cra_top_assertions.sv ====
// Checker of the count rate averager port behaviour.
`timescale 1ns/10ps
module cra_top_assertions #(
  parameter int SAMPLE_W = 24
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic                sample_valid_i,
  input wire logic                sample_ready_o,
  input wire logic                jmp_2pct_i,
  input wire logic                jmp_5pct_i,
  input wire logic                jmp_10pct_i,
  input wire logic [31:0]         display_o,
  input wire logic                display_stb_o,
  input wire logic                alarm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // The bus answers one cycle after a request is taken, for one cycle only.
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i >= 8'h1C |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  // Shown value and alarm move only together with the refresh strobe.
  a_stb_pulse: assert property (display_stb_o |=> !display_stb_o)
    else $error("refresh strobe too long");
  a_display_held: assert property ($changed(display_o) |-> display_stb_o)
    else $error("display changed without refresh");
  a_alarm_held: assert property ($changed(alarm_o) |-> display_stb_o)
    else $error("alarm changed without refresh");
  // The FIFO only fills on a take, and ready returns within 600 cycles.
  a_full_on_take: assert property ($fell(sample_ready_o) |-> $past(sample_valid_i))
    else $error("ready fell without a take");
  a_ready_back: assert property (!sample_ready_o |-> ##[1:600] sample_ready_o)
    else $error("full FIFO never drained");
  c_alarm: cover property (display_stb_o && alarm_o);
  c_full: cover property (!sample_ready_o);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule

bind cra_top cra_top_assertions #(.SAMPLE_W(SAMPLE_W)) i_cra_top_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
  .sample_ready_o(sample_ready_o), .jmp_2pct_i(jmp_2pct_i), .jmp_5pct_i(jmp_5pct_i),
  .jmp_10pct_i(jmp_10pct_i), .display_o(display_o), .display_stb_o(display_stb_o),
  .alarm_o(alarm_o));

// ==== cra_src_model.sv ====
// Sample source model: offers queued samples, each held until taken.
`timescale 1ns/10ps
module cra_src_model #(
  parameter int W = 24
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         push_i,
  input  wire logic [W-1:0] push_val_i,
  input  wire logic         ready_i,
  output logic [W-1:0]      data_o,
  output logic              valid_o,
  output int                taken_o
);
  logic [W-1:0] q[$];
  // When idle the data lines toggle, so a stale word never looks like a sample.
  always @(posedge clk_i) begin
    if (rst_i) begin
      q.delete();
      valid_o <= 1'b0;
      data_o  <= '0;
      taken_o <= 0;
    end else begin
      if (valid_o && ready_i) begin
        void'(q.pop_front());
        taken_o <= taken_o + 1;
      end
      if (push_i) q.push_back(push_val_i);
      valid_o <= (q.size() != 0);
      data_o  <= (q.size() != 0) ? q[0] : ~data_o;
    end
  end
endmodule

// ==== cra_top_tb.sv ====
// Self-checking bench for the count rate averager.
`timescale 1ns/10ps
module cra_top_tb;
  localparam int TICK = 200;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb_r = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd_q;
  logic [31:0] dat_o;
  logic [31:0] disp;
  logic        push = 1'b0;
  logic [23:0] push_val = 24'h0;
  logic [2:0]  jmp = 3'h0;
  logic [23:0] smp;
  logic        smp_v, smp_rdy, stb, alarm, ack;
  logic [23:0] mdl[$];
  int          taken;
  int          n_stb = 0;
  int          n_mismatch = 0;
  int          n_tests = 0;

  cra_top #(.TICK_CYCLES(TICK)) i_cra_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb_r), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sample_i(smp), .sample_valid_i(smp_v), .sample_ready_o(smp_rdy), .jmp_2pct_i(jmp[2]),
    .jmp_5pct_i(jmp[1]), .jmp_10pct_i(jmp[0]), .display_o(disp), .display_stb_o(stb),
    .alarm_o(alarm));
  cra_src_model i_cra_src_model (.clk_i(clk_i), .rst_i(rst_i), .push_i(push),
    .push_val_i(push_val), .ready_i(smp_rdy), .data_o(smp), .valid_o(smp_v), .taken_o(taken));

  // Clock and a refresh counter sampled mid-cycle, where outputs are settled.
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) if (stb === 1'b1) n_stb++;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One classic bus cycle; the request stands until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb_r <= 1'b1;
    we    <= w;
    adr   <= a;
    dat   <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd_q = dat_o;
    cyc   <= 1'b0;
    stb_r <= 1'b0;
  endtask

  // Hand one sample over, then wait a bounded time for the refresh it causes.
  task automatic feed(input logic [23:0] v, input int lim);
    int s;
    s = n_stb;
    @(posedge clk_i);
    push     <= 1'b1;
    push_val <= v;
    @(posedge clk_i);
    push <= 1'b0;
    repeat (lim) if (n_stb == s) @(negedge clk_i);
  endtask

  // Reset values, a read-only place, an unmapped place, then setpoints.
  task automatic t_regs();
    logic [7:0]  a[4] = '{8'h00, 8'h08, 8'h0C, 8'h10};
    logic [31:0] e[4] = '{32'h0, 32'h00010000, 32'hFFFFFFFF, 32'h0};
    wb(1'b1, 8'h10, 32'h12345678);
    wb(1'b1, 8'h1C, 32'h5A5A5A5A);
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h0);
      check(rd_q, e[i]);
    end
    wb(1'b0, 8'h1C, 32'h0);
    check(rd_q, 32'h0);
    wb(1'b1, 8'h04, 32'h1F4);
    wb(1'b1, 8'h0C, 32'h7D0);
    wb(1'b0, 8'h04, 32'h0);
    check(rd_q, 32'h1F4);
  endtask

  // Each strap alone picks its mode; none or several mean normal mode.
  task automatic t_jumpers();
    logic [2:0] j[5] = '{3'h4, 3'h2, 3'h1, 3'h6, 3'h0};
    logic [1:0] m[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    foreach (j[i]) begin
      @(posedge clk_i);
      jmp <= j[i];
      repeat (8) @(posedge clk_i);
      wb(1'b0, 8'h18, 32'h0);
      check(rd_q[1:0], m[i]);
    end
  endtask

  // A step from 1000 to 3000 counts; every refresh shows the truncated mean.
  task automatic t_normal();
    longint unsigned sum;
    logic [23:0] v;
    for (int i = 0; i < 81; i++) begin
      v = (i < 20) ? 24'h3E8 : 24'hBB8;
      mdl.push_back(v);
      if (mdl.size() > 60) void'(mdl.pop_front());
      sum = 0;
      foreach (mdl[k]) sum += mdl[k];
      feed(v, 2 * TICK + 200);
      check(disp, 32'(sum / mdl.size()));
      check(alarm, 32'(sum / mdl.size() >= 32'h9C4));
    end
  endtask

  // The FIFO fills and refuses; the source stalls, then all words drain.
  task automatic t_fifo();
    int s;
    s = n_stb;
    wb(1'b1, 8'h00, 32'h00100000);
    @(posedge clk_i);
    push     <= 1'b1;
    push_val <= 24'hBB8;
    repeat (20) @(posedge clk_i);
    push <= 1'b0;
    repeat (100) if (smp_rdy !== 1'b0) @(negedge clk_i);
    check(smp_rdy, 32'h0);
    repeat (25 * TICK) if (n_stb - s < 20) @(negedge clk_i);
    check(n_stb - s, 20);
    check(disp, 32'hBC0);
    check(smp_rdy, 32'h1);
    check(taken, 101);
  endtask

  // Ten percent mode: steady input refreshes seldom, a jump refreshes at once.
  task automatic t_accuracy();
    int s;
    @(posedge clk_i);
    jmp <= 3'h1;
    repeat (8) @(posedge clk_i);
    s = n_stb;
    repeat (70) feed(24'h64, TICK);
    check(n_stb - s, 2);
    s = n_stb;
    feed(24'h2710, 5 * TICK);
    check(n_stb - s, 1);
    wb(1'b0, 8'h18, 32'h0);
    check(rd_q[2], 1'b1);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_jumpers();
    t_normal();
    t_fifo();
    t_accuracy();
    print_verdict();
  end

  // Watchdog: the tests need about thirty-five thousand cycles.
  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end
endmodule
